// ==== pkg/fifo_thresh_pkg.sv ====
// Package with register map, field positions, reset values and carrier types.
package fifo_thresh_pkg;
	localparam logic [7:0] off_fifo_diag_control = 8'h3a;
	localparam logic [7:0] off_rx_early_byte_threshold = 8'h3e;
	localparam logic [7:0] off_tx_release_threshold = 8'h5d;
	localparam int bit_ram_test = 0;
	localparam int bit_keep_overrun = 9;
	localparam int bit_rx_full = 11;
	localparam int bit_transmitting = 14;
	localparam int bit_receiving = 15;
	localparam logic [15:0] ctrl_write_mask = 16'h0201;
	localparam logic [12:0] rx_early_reset = 13'h1ffc;
	localparam logic [12:0] rx_early_disabled = 13'h1ffc;
	localparam logic [12:0] rx_early_min = 13'h0008;
	localparam logic [12:0] rx_early_grain_mask = 13'h1ffc;
	localparam logic [7:0] tx_release_reset = 8'h08;
	localparam logic [7:0] tx_release_disabled = 8'hff;
	localparam int tx_release_unit_shift = 4;
	localparam int tx_status_release_bit = 1;
	localparam int rx_fifo_depth = 8;
	localparam int rx_fifo_width = 8;
	localparam int frame_tag_width = 8;

	typedef struct packed {
		logic [7:0] data;
		logic last;
	} rx_beat_t;

	typedef struct packed {
		logic [7:0] status;
		logic [7:0] tag;
	} tx_status_t;
endpackage

// ==== rtl/mac_fifo_threshold_control.sv ====
// FIFO control, receive early threshold and transmit release threshold logic.
`timescale 1ns/100ps
`default_nettype none

module rx_byte_fifo #(
	parameter int width = 9,
	parameter int depth = 8
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [width-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [width-1:0] out_data,
	output logic full
);
	localparam int aw = $clog2(depth);
	logic [width-1:0] mem [depth];
	logic [aw-1:0] wr_ptr;
	logic [aw-1:0] rd_ptr;
	logic [aw:0] count;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	assign full = (count == (aw+1)'(depth));
	assign in_ready = !full;
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == aw'(depth - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == aw'(depth - 1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (aw+1)'(push) - (aw+1)'(pop);
		end
	end
endmodule

// ----------------------------------------------------------------------
// Overview of operation
// ----------------------------------------------------------------------
// Overview of operation
// - FIFO control bit 0 puts FIFO RAM in test mode; reset clears it.
// - Bit 9 clear discards overrun frames; set keeps exposed overrun frames visible.
// - Bit 11 reads high while receive FIFO is full, drops when not full.
// - Receive data arriving while receive FIFO is full marks the frame overrun.
// - Bit 14 is high while the MAC transmits or defers.
// - Bit 15 is high while a frame is received into the receive FIFO.
// - Receive early event rises when head frame bytes reach the early threshold.
// - The first destination address byte counts as byte one.
// - With the early gate set, receive DMA waits until threshold bytes or a whole frame arrived.
// - Early threshold resets to 1ffc, which disables the mechanism.
// - Early threshold below 8 acts as 8; above uses 4-byte steps.
// - At the release threshold that many bytes free; then each sent byte frees.
// - Release threshold is eight bits in units of 16 bytes.
// - Release threshold resets to 8, a release point of 128 bytes.
// - Release threshold 255 frees space only after the whole frame is sent.
// - Collision after release crossing means no retry and a release fault status.
// - A release fault disables the transmitter and exposes the frame tag.
// - The release fault is bit 1 of each transmit status entry.
// - Early event held on receive_early_event, withdrawn at frame end with receive-complete.
module mac_fifo_threshold_control (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] reg_addr,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	input wire logic rx_in_valid,
	output logic rx_in_ready,
	input wire logic [7:0] rx_in_data,
	input wire logic rx_in_last,
	output logic rx_out_valid,
	input wire logic rx_out_ready,
	output logic [7:0] rx_out_data,
	output logic rx_out_last,
	output logic rx_overrun,
	output logic rx_discard_overrun,
	input wire logic receive_dma_early_gate,
	output logic receive_dma_start_allowed,
	output logic receive_early_event,
	output logic rx_complete_event,
	output logic fifo_ram_test_enable,
	input wire logic mac_transmitting,
	input wire logic mac_deferring,
	input wire logic tx_byte_sent,
	input wire logic tx_frame_start,
	input wire logic tx_frame_done,
	input wire logic tx_collision,
	input wire logic [7:0] tx_frame_id,
	output logic [10:0] tx_free_bytes,
	output logic tx_free_valid,
	output logic tx_retry_allowed,
	output logic tx_status_push,
	output logic [7:0] tx_status_entry,
	output logic tx_disable,
	output logic [7:0] transmit_frame_tag
);
	// ----------------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------------
	logic ram_test;
	logic keep_overrun;
	logic [12:0] early_thresh;
	logic [7:0] release_thresh;

	wire hit_ctrl = reg_addr == fifo_thresh_pkg::off_fifo_diag_control;
	wire hit_early = reg_addr == fifo_thresh_pkg::off_rx_early_byte_threshold;
	wire hit_release = reg_addr == fifo_thresh_pkg::off_tx_release_threshold;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ram_test <= 1'b0;
			keep_overrun <= 1'b0;
			early_thresh <= fifo_thresh_pkg::rx_early_reset;
			release_thresh <= fifo_thresh_pkg::tx_release_reset;
		end else if (reg_write) begin
			if (hit_ctrl) begin
				// Only writable bits are taken; flag positions are dropped.
				ram_test <= reg_wdata[fifo_thresh_pkg::bit_ram_test];
				keep_overrun <= reg_wdata[fifo_thresh_pkg::bit_keep_overrun];
			end
			if (hit_early) begin
				early_thresh <= reg_wdata[12:0];
			end
			if (hit_release) begin
				release_thresh <= reg_wdata[7:0];
			end
		end
	end
	assign fifo_ram_test_enable = ram_test;

	// ----------------------------------------------------------------------
	// Receive path
	// ----------------------------------------------------------------------
	logic fifo_full;
	logic receiving;
	logic frame_overrun;
	logic [12:0] head_count;
	logic early_hit;
	localparam int fw = $clog2(fifo_thresh_pkg::rx_fifo_depth) + 1;
	logic [fw-1:0] whole_frames;
	fifo_thresh_pkg::rx_beat_t in_beat;
	fifo_thresh_pkg::rx_beat_t out_beat;
	assign in_beat.data = rx_in_data;
	assign in_beat.last = rx_in_last;

	rx_byte_fifo #(
		.width(fifo_thresh_pkg::rx_fifo_width + 1),
		.depth(fifo_thresh_pkg::rx_fifo_depth)
	) u_rx_fifo (
		.clk(clk),
		.resetn(resetn),
		.in_valid(rx_in_valid),
		.in_ready(rx_in_ready),
		.in_data(in_beat),
		.out_valid(rx_out_valid),
		.out_ready(rx_out_ready),
		.out_data(out_beat),
		.full(fifo_full)
	);
	assign rx_out_data = out_beat.data;
	assign rx_out_last = out_beat.last;

	// Data offered while full is lost, so the frame is marked overrun.
	wire overrun_now = rx_in_valid && fifo_full;
	wire rx_push = rx_in_valid && rx_in_ready;
	wire frame_end = rx_push && rx_in_last;
	// A frame that has fully arrived may always be drained, or a gated frame would stall.
	wire tail_pop = rx_out_valid && rx_out_ready && rx_out_last;

	// Below the floor the floor applies; the low two bits are dropped for 4-byte steps.
	wire [12:0] early_eff = (early_thresh < fifo_thresh_pkg::rx_early_min) ?
		fifo_thresh_pkg::rx_early_min :
		(early_thresh & fifo_thresh_pkg::rx_early_grain_mask);
	wire early_enabled = early_thresh != fifo_thresh_pkg::rx_early_disabled;
	// Count includes the byte taken this cycle, so the first byte is byte one.
	wire [12:0] next_head_count = head_count + 13'(rx_push);
	wire early_reached = next_head_count >= early_eff;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			receiving <= 1'b0;
			frame_overrun <= 1'b0;
			head_count <= '0;
			early_hit <= 1'b0;
			rx_complete_event <= 1'b0;
			rx_overrun <= 1'b0;
			rx_discard_overrun <= 1'b0;
			whole_frames <= '0;
		end else begin
			whole_frames <= whole_frames + fw'(frame_end) - fw'(tail_pop);
			rx_complete_event <= frame_end;
			rx_overrun <= overrun_now && !frame_overrun;
			rx_discard_overrun <= 1'b0;
			if (frame_end) begin
				receiving <= 1'b0;
				head_count <= '0;
				early_hit <= 1'b0;
				frame_overrun <= 1'b0;
				rx_discard_overrun <= (frame_overrun || overrun_now) && !keep_overrun;
			end else begin
				if (rx_in_valid) begin
					receiving <= 1'b1;
				end
				if (overrun_now) begin
					frame_overrun <= 1'b1;
				end
				head_count <= next_head_count;
				if (early_enabled && early_reached && rx_push) begin
					early_hit <= 1'b1;
				end
			end
		end
	end
	assign receive_early_event = early_hit;
	assign receive_dma_start_allowed = !receive_dma_early_gate || !early_enabled ||
		early_hit || whole_frames != '0;

	// ----------------------------------------------------------------------
	// Transmit release
	// ----------------------------------------------------------------------
	logic [10:0] sent_count;
	logic released;
	logic fault_latched;
	logic [7:0] tag;
	logic [7:0] frame_id;
	wire release_disabled = release_thresh == fifo_thresh_pkg::tx_release_disabled;
	wire [11:0] release_bytes = {release_thresh, 4'h0};
	wire [11:0] next_sent = {1'b0, sent_count} + 12'(tx_byte_sent);
	wire cross_now = !release_disabled && !released && tx_byte_sent &&
		next_sent == release_bytes;
	wire fault_now = tx_collision && released;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sent_count <= '0;
			released <= 1'b0;
			tx_free_bytes <= '0;
			tx_free_valid <= 1'b0;
			tx_status_push <= 1'b0;
			tx_status_entry <= '0;
			fault_latched <= 1'b0;
			tag <= '0;
			frame_id <= '0;
		end else begin
			tx_free_valid <= 1'b0;
			tx_status_push <= 1'b0;
			if (tx_frame_start) begin
				sent_count <= '0;
				released <= 1'b0;
				frame_id <= tx_frame_id;
			end else begin
				sent_count <= next_sent[10:0];
				if (cross_now) begin
					released <= 1'b1;
					tx_free_bytes <= next_sent[10:0];
					tx_free_valid <= 1'b1;
				end else if (released && tx_byte_sent) begin
					tx_free_bytes <= 11'h001;
					tx_free_valid <= 1'b1;
				end else if (tx_frame_done && !released) begin
					tx_free_bytes <= sent_count;
					tx_free_valid <= 1'b1;
				end
			end
			if (fault_now) begin
				tx_status_push <= 1'b1;
				tx_status_entry <= 8'h01 << fifo_thresh_pkg::tx_status_release_bit;
				fault_latched <= 1'b1;
				tag <= frame_id;
			end else if (reg_write && hit_release) begin
				// Reprogramming the threshold rearms the transmitter.
				fault_latched <= 1'b0;
			end
		end
	end
	assign tx_retry_allowed = !released;
	assign tx_disable = fault_latched;
	assign transmit_frame_tag = tag;

	// ----------------------------------------------------------------------
	// Read back
	// ----------------------------------------------------------------------
	logic [15:0] ctrl_view;
	always_comb begin
		ctrl_view = '0;
		ctrl_view[fifo_thresh_pkg::bit_ram_test] = ram_test;
		ctrl_view[fifo_thresh_pkg::bit_keep_overrun] = keep_overrun;
		ctrl_view[fifo_thresh_pkg::bit_rx_full] = fifo_full;
		ctrl_view[fifo_thresh_pkg::bit_transmitting] = mac_transmitting || mac_deferring;
		ctrl_view[fifo_thresh_pkg::bit_receiving] = receiving;
	end

	wire [15:0] read_mux = hit_ctrl ? ctrl_view :
		hit_early ? {3'b000, early_thresh} :
		hit_release ? {8'h00, release_thresh} : 16'h0000;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= '0;
		end else if (reg_read) begin
			reg_rdata <= read_mux;
		end
	end
endmodule

`default_nettype wire

// ==== tb/fifo_thresh_monitor.sv ====
// Checker of port timing relations for the FIFO threshold control block.
`timescale 1ns/100ps
`default_nettype none
module fifo_thresh_monitor (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] reg_addr,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic rx_in_valid,
	input wire logic rx_in_ready,
	input wire logic rx_in_last,
	input wire logic rx_overrun,
	input wire logic receive_dma_early_gate,
	input wire logic receive_dma_start_allowed,
	input wire logic receive_early_event,
	input wire logic rx_complete_event,
	input wire logic fifo_ram_test_enable,
	input wire logic mac_transmitting,
	input wire logic mac_deferring,
	input wire logic tx_collision,
	input wire logic tx_status_push,
	input wire logic [7:0] tx_status_entry,
	input wire logic tx_disable
);
	// ----
	// Properties
	// ----
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence ctrl_rd;
		reg_read && reg_addr == 8'h3a;
	endsequence
	sequence last_in;
		rx_in_valid && rx_in_ready && rx_in_last;
	endsequence
	full_flag_a: assert property (ctrl_rd |=> reg_rdata[11] == $past(!rx_in_ready))
		else $error("full flag does not follow the fifo state");
	tx_flag_a: assert property (ctrl_rd |=> reg_rdata[14] == $past(mac_transmitting || mac_deferring))
		else $error("transmit activity flag wrong");
	reserved_bits_a: assert property (ctrl_rd |=> reg_rdata[13:12] == 2'h0 && reg_rdata[10] == 1'b0 &&
		reg_rdata[8:1] == 8'h00)
		else $error("reserved control bits not zero");
	test_mode_a: assert property (reg_write && reg_addr == 8'h3a |=> fifo_ram_test_enable == $past(reg_wdata[0]))
		else $error("test mode bit not taken from write");
	overrun_cause_a: assert property (rx_overrun |-> $past(rx_in_valid && !rx_in_ready))
		else $error("overrun without data while full");
	early_end_a: assert property (last_in |=> rx_complete_event && !receive_early_event)
		else $error("early event not withdrawn at frame end");
	dma_gate_a: assert property (!receive_dma_early_gate || receive_early_event |-> receive_dma_start_allowed)
		else $error("receive dma held without cause");
	fault_push_a: assert property (tx_status_push |-> tx_disable && tx_status_entry[1])
		else $error("status push without release fault and disable");
	no_retry_a: assert property ($rose(tx_disable) |-> $past(tx_collision) || $past(tx_collision, 2))
		else $error("transmitter disabled without collision");
endmodule
bind mac_fifo_threshold_control fifo_thresh_monitor mon_u (.clk, .resetn, .reg_addr, .reg_write,
	.reg_read, .reg_wdata, .reg_rdata, .rx_in_valid, .rx_in_ready, .rx_in_last, .rx_overrun,
	.receive_dma_early_gate, .receive_dma_start_allowed, .receive_early_event, .rx_complete_event,
	.fifo_ram_test_enable, .mac_transmitting, .mac_deferring, .tx_collision, .tx_status_push,
	.tx_status_entry, .tx_disable);
`default_nettype wire

// ==== tb/rx_dma_sink.sv ====
// Receive DMA model that drains the receive FIFO, with a stall input.
`timescale 1ns/100ps
`default_nettype none
module rx_dma_sink (
	input wire logic clk,
	input wire logic resetn,
	input wire logic stall,
	input wire logic allowed,
	input wire logic valid,
	output logic ready,
	output logic [15:0] count
);
	// Ready moves just after the edge, so the FIFO never sees it change mid-cycle.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ready <= 1'b0;
			count <= 16'h0000;
		end else begin
			if (valid && ready) count <= count + 16'h0001;
			ready <= #1 !stall && allowed;
		end
	end
endmodule
`default_nettype wire

// ==== tb/mac_fifo_threshold_control_tb.sv ====
// Self-checking testbench of the FIFO threshold control block.
`timescale 1ns/100ps
`default_nettype none
module mac_fifo_threshold_control_tb;
	logic clk, resetn, reg_write, reg_read, rx_in_valid, rx_in_ready, rx_in_last, rx_out_valid;
	logic rx_out_ready, rx_overrun, rx_discard_overrun, receive_dma_early_gate, stall;
	logic receive_dma_start_allowed, receive_early_event, rx_complete_event, fifo_ram_test_enable;
	logic mac_transmitting, mac_deferring, tx_byte_sent, tx_frame_start, tx_frame_done;
	logic tx_collision, tx_free_valid, tx_status_push, tx_disable;
	logic [7:0] reg_addr, rx_in_data, tx_frame_id, tx_status_entry, transmit_frame_tag, id;
	logic [7:0] rx_out_data;
	logic [7:0] sent_x = 8'h00;
	logic [7:0] got_x = 8'h00;
	logic rx_out_last, tx_retry_allowed;
	int lasts;
	logic [15:0] reg_wdata, reg_rdata, count;
	logic [10:0] tx_free_bytes;
	int errors, compares;
	mac_fifo_threshold_control dut_u (.clk, .resetn, .reg_addr, .reg_write, .reg_read,
		.reg_wdata, .reg_rdata, .rx_in_valid, .rx_in_ready, .rx_in_data, .rx_in_last,
		.rx_out_valid, .rx_out_ready, .rx_out_data, .rx_out_last, .rx_overrun,
		.rx_discard_overrun, .receive_dma_early_gate, .receive_dma_start_allowed,
		.receive_early_event, .rx_complete_event, .fifo_ram_test_enable, .mac_transmitting,
		.mac_deferring, .tx_byte_sent, .tx_frame_start, .tx_frame_done, .tx_collision,
		.tx_frame_id, .tx_free_bytes, .tx_free_valid, .tx_retry_allowed, .tx_status_push,
		.tx_status_entry, .tx_disable, .transmit_frame_tag);
	rx_dma_sink sink_u (.clk, .resetn, .stall, .allowed(receive_dma_start_allowed),
		.valid(rx_out_valid), .ready(rx_out_ready), .count);
	// Drained bytes are folded into a checksum so that lost or doubled bytes show up.
	always @(posedge clk) begin
		if (rx_out_valid && rx_out_ready) begin
			got_x <= got_x ^ rx_out_data;
			lasts <= lasts + (rx_out_last ? 1 : 0);
		end
	end
	// ----
	// Tasks
	// ----
	task automatic final_report();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic ok, input string m);
		compares++;
		if (ok !== 1'b1) begin
			errors++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	function automatic logic [15:0] fctl(input logic b15, input logic b11, input logic [15:0] w);
		return {b15, mac_transmitting | mac_deferring, 2'b00, b11, 11'h000} | (w & 16'h0201);
	endfunction
	function automatic logic [12:0] eff(input logic [12:0] v);
		return (v & 13'h1ffc) < 13'h0008 ? 13'h0008 : (v & 13'h1ffc);
	endfunction
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_write = 1'b1;
		@(posedge clk) #1 reg_write = 1'b0;
		@(posedge clk) #1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		reg_addr = a;
		reg_read = 1'b1;
		@(posedge clk) #1 reg_read = 1'b0;
		chk(reg_rdata === e, "register read mismatch");
		@(posedge clk) #1;
	endtask
	task automatic snd(input logic l);
		int k;
		k = 0;
		rx_in_data = 8'($urandom);
		rx_in_last = l;
		rx_in_valid = 1'b1;
		while (rx_in_ready !== 1'b1 && k < 50) begin
			@(posedge clk) #1;
			k++;
		end
		@(posedge clk) #1;
		sent_x = sent_x ^ rx_in_data;
	endtask
	task automatic drain();
		int k;
		k = 0;
		while (rx_out_valid !== 1'b0 && k < 50) begin
			@(posedge clk) #1;
			k++;
		end
	endtask
	task automatic efr(input logic [12:0] v, input int n);
		logic [15:0] c0;
		int l0;
		wr(8'h3e, {3'h0, v});
		receive_dma_early_gate = (eff(v) == 13'h0008);
		c0 = count;
		l0 = lasts;
		for (int i = 1; i <= n; i++) begin
			snd(i == n);
			if (i < n) chk(receive_early_event === (i >= eff(v)), "early event timing");
			if (receive_dma_early_gate && i < eff(v)) chk(count === c0, "dma started early");
		end
		rx_in_valid = 1'b0;
		drain();
		chk(count - c0 === 16'(n), "receive dma byte count");
		chk(got_x === sent_x && lasts - l0 === 1, "receive data or frame end lost");
		$display("test early threshold %0h done", v);
	endtask
	task automatic txf(input int n, input int thr);
		int k;
		tx_frame_id = id;
		tx_frame_start = 1'b1;
		@(posedge clk) #1 tx_frame_start = 1'b0;
		tx_byte_sent = 1'b1;
		for (int i = 1; i <= n; i++) begin
			@(posedge clk) #1;
			chk(tx_free_valid === (thr != 0 && i >= thr), "release pulse timing");
			chk(tx_retry_allowed === !(thr != 0 && i >= thr), "retry after release");
			if (thr != 0 && i >= thr) chk(tx_free_bytes === 11'(i == thr ? thr : 1), "free count");
		end
		tx_byte_sent = 1'b0;
		if (thr == 0) begin
			tx_frame_done = 1'b1;
			@(posedge clk) #1 tx_frame_done = 1'b0;
			for (k = 0; k < 5 && tx_free_valid !== 1'b1; k++) @(posedge clk) #1;
			chk(tx_free_valid === 1'b1 && tx_free_bytes === 11'(n), "whole frame freed");
		end
		$display("test transmit frame %0d done", n);
	endtask
	// ----
	// Sequence
	// ----
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		#100000;
		errors++;
		final_report();
	end
	initial begin
		{resetn, reg_write, reg_read, rx_in_valid, rx_in_last, receive_dma_early_gate} = 6'h00;
		{stall, tx_byte_sent, tx_frame_start, tx_frame_done, tx_collision} = 5'h00;
		{reg_addr, reg_wdata, rx_in_data, tx_frame_id} = 40'h0;
		void'($urandom(87776));
		{mac_transmitting, mac_deferring} = 2'($urandom);
		id = 8'($urandom);
		repeat (3) @(posedge clk);
		#1 resetn = 1'b1;
		rd(8'h3e, 16'h1ffc);
		rd(8'h5d, 16'h0008);
		rd(8'h3a, fctl(1'b0, 1'b0, 16'h0000));
		rd(8'h10, 16'h0000);
		wr(8'h3a, 16'hca01);
		rd(8'h3a, fctl(1'b0, 1'b0, 16'hca01));
		chk(fifo_ram_test_enable === 1'b1, "test mode not set");
		wr(8'h3a, 16'h0000);
		$display("test control register done");
		for (int m = 0; m < 2; m++) begin
			wr(8'h3a, 16'(m) << 9);
			stall = 1'b1;
			for (int i = 0; i < 8; i++) snd(1'b0);
			@(posedge clk) #1;
			chk(rx_overrun === 1'b1, "no overrun on data while full");
			rx_in_valid = 1'b0;
			rd(8'h3a, fctl(1'b1, 1'b1, 16'(m) << 9));
			stall = 1'b0;
			snd(1'b1);
			rx_in_valid = 1'b0;
			for (int k = 0; k < 10 && rx_discard_overrun !== 1'b1; k++) @(posedge clk) #1;
			chk(rx_discard_overrun === (m == 0), "overrun frame handling wrong");
			drain();
			rd(8'h3a, fctl(1'b0, 1'b0, 16'(m) << 9));
		end
		$display("test overrun done");
		efr(13'($urandom % 12), 10);
		efr(13'h000d, 14);
		efr(13'h1ffc, 10);
		wr(8'h5d, 16'h0004);
		txf(65, 64);
		tx_collision = 1'b1;
		@(posedge clk) #1 tx_collision = 1'b0;
		for (int k = 0; k < 5 && tx_status_push !== 1'b1; k++) @(posedge clk) #1;
		chk(tx_status_push === 1'b1 && tx_status_entry === 8'h02, "no fault status");
		chk(tx_disable === 1'b1 && transmit_frame_tag === id, "fault tag");
		wr(8'h5d, 16'h00ff);
		txf(20, 0);
		final_report();
	end
endmodule
`default_nettype wire
